/* design/eip_map.svh */
// Register offsets, reset values, field positions and vector numbers of the interrupt prioritizer
`ifndef EIP_MAP_SVH
`define EIP_MAP_SVH

`define EIP_ADDR_W 16
`define EIP_DATA_W 8

`define EIP_OFF_EDGE_POLARITY_SELECT 16'hfff2
`define EIP_OFF_SOURCE_ENABLE_FIRST 16'hfff3
`define EIP_OFF_SOURCE_ENABLE_SECOND 16'hfff4
`define EIP_OFF_PENDING_FLAGS_FIRST 16'hfff6
`define EIP_OFF_PENDING_FLAGS_SECOND 16'hfff7
`define EIP_OFF_WAKEUP_PENDING_FLAGS 16'hfff9
`define EIP_OFF_EVENT_STATUS 16'hfffa
`define EIP_OFF_EVENT_MASK 16'hfffb

`define EIP_RST_EDGE_POLARITY_SELECT 8'he0
`define EIP_RST_SOURCE_ENABLE 8'h00
`define EIP_RST_PENDING_FLAGS_FIRST 8'h20
`define EIP_RST_PENDING_FLAGS_SECOND 8'h00
`define EIP_RST_WAKEUP_PENDING_FLAGS 8'h00
`define EIP_RST_EVENT 3'h0

`define EIP_EDGE_SEL_FIXED 8'he0
`define EIP_EDGE_SEL_MASK 5'h1f
`define EIP_EDGE_SEL_MASK_REDUCED 5'h1b

// Implemented pending bits per variant
`define EIP_FIRST_MASK_FULL 8'hdf
`define EIP_FIRST_MASK_REDUCED 8'h9b
`define EIP_SECOND_MASK_FULL 8'hcf
`define EIP_SECOND_MASK_REDUCED 8'hcd

// First enable/pending register fields
`define EIP_BIT_TA 7
`define EIP_BIT_S1 6
`define EIP_BIT_WP 5
// Second enable/pending register fields
`define EIP_BIT_DT 7
`define EIP_BIT_AD 6
`define EIP_BIT_TFH 3
`define EIP_BIT_TFL 2
`define EIP_BIT_TC 1
`define EIP_BIT_TB 0

`define EIP_EDGE_PINS 5
`define EIP_WAKE_PINS 8

`define EIP_VEC_EDGE0 5'h04
`define EIP_VEC_WAKEUP 5'h09
`define EIP_VEC_S1 5'h0a
`define EIP_VEC_TA 5'h0b
`define EIP_VEC_TB 5'h0c
`define EIP_VEC_TC 5'h0d
`define EIP_VEC_TFL 5'h0e
`define EIP_VEC_TFH 5'h0f
`define EIP_VEC_SERIAL_UNIT_THREE 5'h12
`define EIP_VEC_AD 5'h13
`define EIP_VEC_DT 5'h14
`define EIP_VEC_COUNT 21

// Event status bits
`define EIP_EVT_EDGE 0
`define EIP_EVT_ACCEPT 1
`define EIP_EVT_HELD 2

`endif

/* design/eip_pkg.sv */
// Types shared by the interrupt prioritizer modules
package eip_pkg;

  typedef logic [15:0] eip_addr_t;
  typedef logic [7:0] eip_byte_t;
  typedef logic [4:0] eip_vec_t;

  typedef struct packed {
    logic [4:0] edge_sel;
    eip_byte_t enable_first;
    eip_byte_t enable_second;
    eip_byte_t pending_first;
    eip_byte_t pending_second;
    eip_byte_t wake_pending;
    logic [4:0] edge_prev;
    logic [7:0] wake_prev;
    logic armed;
    logic [2:0] evt_status;
    logic [2:0] evt_mask;
    eip_byte_t rdata;
    logic cpu_req;
    eip_vec_t vec;
    eip_addr_t vec_addr;
    logic irq;
  } eip_state_t;

endpackage

/* design/eip_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous pin levels
module eip_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } eip_sync_state_t;

  eip_sync_state_t state_reg;
  eip_sync_state_t state_next;

  always_comb
  begin
    state_next.meta = async_i;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg.meta <= RST_VAL;
      state_reg.stable <= RST_VAL;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;

endmodule

/* design/eip_top.sv */
// Edge interrupt prioritizer: pin sensing, request flags, enables and vector selection
//
// Overview of operation
// - Highest fixed-priority pending request is serviced first
// - Global mask set: flags still set, nothing accepted
// - Each edge pin has its own edge choice
// - Edge pins use vectors 4-8; wakeups share 9
// - Full variant: 13 external, 9 internal sources
// - Serial one 10, timers 11 to 15
// - Serial three 18, converter 19, direct transfer 20
// - Reserved vector slots are never selected
// - Reduced variant drops pin 2, serial one, timer C; pin 2 edges still set the edge event
// - Flags clear only by writing 0
// - Edge-select bits 7-5 read 1, ignore writes
// - Edge-select 0 falling, 1 rising
// - Edge-select bits 4-0 map to pins 4-0
// - Acceptance waits for instruction boundary
// - Flags stay set after acceptance
// - Per-source enable gates each request except serial three, which is never gated
`include "eip_map.svh"

module eip_top #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Register port
  input wire eip_pkg::eip_addr_t reg_addr_i,
  input wire eip_pkg::eip_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output eip_pkg::eip_byte_t reg_rdata_o,
  // Pins; pin 4 doubles as converter trigger, pins 3..1 as timer event inputs
  input wire logic [4:0] edge_pin_i,
  input wire logic [7:0] wakeup_pin_n_i,
  // Peripheral request pulses; the serial three request is a level, not latched
  input wire logic timer_a_evt_i,
  input wire logic serial_one_evt_i,
  input wire logic timer_b_evt_i,
  input wire logic timer_c_evt_i,
  input wire logic timer_fl_evt_i,
  input wire logic timer_fh_evt_i,
  input wire logic converter_evt_i,
  input wire logic direct_transfer_evt_i,
  input wire logic serial_three_req_i,
  // CPU core
  input wire logic cpu_imask_i,
  input wire logic cpu_boundary_i,
  output logic cpu_req_o,
  output eip_pkg::eip_vec_t cpu_vector_o,
  output eip_pkg::eip_addr_t cpu_vec_addr_o,
  output logic irq_o
);

  import eip_pkg::*;

  localparam logic [7:0] FIRST_MASK = FULL_VARIANT ? `EIP_FIRST_MASK_FULL : `EIP_FIRST_MASK_REDUCED;
  localparam logic [7:0] SECOND_MASK = FULL_VARIANT ? `EIP_SECOND_MASK_FULL : `EIP_SECOND_MASK_REDUCED;
  localparam logic [4:0] EDGE_MASK = FULL_VARIANT ? `EIP_EDGE_SEL_MASK : `EIP_EDGE_SEL_MASK_REDUCED;

  eip_state_t state_reg;
  eip_state_t state_next;

  logic [4:0] edge_sync;
  logic [7:0] wake_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  eip_sync #(
    .WIDTH(5),
    .RST_VAL(5'h1f)
  ) u_edge_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .async_i(edge_pin_i),
    .sync_o(edge_sync)
  );

  eip_sync #(
    .WIDTH(8),
    .RST_VAL(8'hff)
  ) u_wake_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .async_i(wakeup_pin_n_i),
    .sync_o(wake_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic [4:0] edge_hit;
  logic [7:0] wake_hit;
  logic [7:0] set_first;
  logic [7:0] set_second;
  logic [7:0] keep_first;
  logic [7:0] keep_second;
  logic [7:0] keep_wake;
  logic [`EIP_VEC_COUNT-1:0] vec_pending;
  logic sel_found;
  eip_vec_t sel_vec;
  logic accept;
  logic [2:0] evt_set;
  logic status_rd;

  always_comb
  begin
    state_next = state_reg;
    edge_hit = '0;
    wake_hit = '0;
    set_first = '0;
    set_second = '0;
    keep_first = 8'hff;
    keep_second = 8'hff;
    keep_wake = 8'hff;
    vec_pending = '0;
    sel_found = 1'b0;
    sel_vec = '0;
    evt_set = '0;
    status_rd = 1'b0;

    // Edge sensing; the first cycle after reset only loads the history
    state_next.edge_prev = edge_sync;
    state_next.wake_prev = wake_sync;
    state_next.armed = 1'b1;
    if (state_reg.armed)
    begin
      for (int i = 0; i < `EIP_EDGE_PINS; i++)
      begin
        if (state_reg.edge_sel[i])
          edge_hit[i] = edge_sync[i] & ~state_reg.edge_prev[i];
        else
          edge_hit[i] = ~edge_sync[i] & state_reg.edge_prev[i];
      end
      wake_hit = ~wake_sync & state_reg.wake_prev;
    end

    // Hardware set sources, limited to the variant's implemented bits
    set_first[4:0] = edge_hit;
    set_first[`EIP_BIT_TA] = timer_a_evt_i;
    set_first[`EIP_BIT_S1] = serial_one_evt_i;
    set_first = set_first & FIRST_MASK;
    set_second[`EIP_BIT_DT] = direct_transfer_evt_i;
    set_second[`EIP_BIT_AD] = converter_evt_i;
    set_second[`EIP_BIT_TFH] = timer_fh_evt_i;
    set_second[`EIP_BIT_TFL] = timer_fl_evt_i;
    set_second[`EIP_BIT_TC] = timer_c_evt_i;
    set_second[`EIP_BIT_TB] = timer_b_evt_i;
    set_second = set_second & SECOND_MASK;

    // Register writes
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `EIP_OFF_EDGE_POLARITY_SELECT:
          state_next.edge_sel = reg_wdata_i[4:0];
        `EIP_OFF_SOURCE_ENABLE_FIRST:
          state_next.enable_first = reg_wdata_i;
        `EIP_OFF_SOURCE_ENABLE_SECOND:
          state_next.enable_second = reg_wdata_i;
        `EIP_OFF_PENDING_FLAGS_FIRST:
          keep_first = reg_wdata_i;
        `EIP_OFF_PENDING_FLAGS_SECOND:
          keep_second = reg_wdata_i;
        `EIP_OFF_WAKEUP_PENDING_FLAGS:
          keep_wake = reg_wdata_i;
        `EIP_OFF_EVENT_MASK:
          state_next.evt_mask = reg_wdata_i[2:0];
        default:
          ;
      endcase
    end

    // Flags persist past acceptance; a set in the clearing cycle wins
    state_next.pending_first = ((state_reg.pending_first & keep_first) | set_first) & FIRST_MASK;
    state_next.pending_second = ((state_reg.pending_second & keep_second) | set_second) & SECOND_MASK;
    state_next.wake_pending = (state_reg.wake_pending & keep_wake) | wake_hit;

    // Enabled requests placed by vector number
    for (int i = 0; i < `EIP_EDGE_PINS; i++)
    begin
      vec_pending[`EIP_VEC_EDGE0 + i] = state_reg.pending_first[i] & state_reg.enable_first[i];
    end
    vec_pending[`EIP_VEC_WAKEUP] = (|state_reg.wake_pending) & state_reg.enable_first[`EIP_BIT_WP];
    vec_pending[`EIP_VEC_S1] = state_reg.pending_first[`EIP_BIT_S1] & state_reg.enable_first[`EIP_BIT_S1];
    vec_pending[`EIP_VEC_TA] = state_reg.pending_first[`EIP_BIT_TA] & state_reg.enable_first[`EIP_BIT_TA];
    vec_pending[`EIP_VEC_TB] = state_reg.pending_second[`EIP_BIT_TB] & state_reg.enable_second[`EIP_BIT_TB];
    vec_pending[`EIP_VEC_TC] = state_reg.pending_second[`EIP_BIT_TC] & state_reg.enable_second[`EIP_BIT_TC];
    vec_pending[`EIP_VEC_TFL] = state_reg.pending_second[`EIP_BIT_TFL] & state_reg.enable_second[`EIP_BIT_TFL];
    vec_pending[`EIP_VEC_TFH] = state_reg.pending_second[`EIP_BIT_TFH] & state_reg.enable_second[`EIP_BIT_TFH];
    vec_pending[`EIP_VEC_SERIAL_UNIT_THREE] = serial_three_req_i;
    vec_pending[`EIP_VEC_AD] = state_reg.pending_second[`EIP_BIT_AD] & state_reg.enable_second[`EIP_BIT_AD];
    vec_pending[`EIP_VEC_DT] = state_reg.pending_second[`EIP_BIT_DT] & state_reg.enable_second[`EIP_BIT_DT];

    // Lowest vector number wins; reserved slots are never driven
    for (int v = `EIP_VEC_COUNT - 1; v >= 0; v--)
    begin
      if (vec_pending[v])
      begin
        sel_found = 1'b1;
        sel_vec = eip_vec_t'(v);
      end
    end

    // Acceptance only at a boundary and with the global mask clear
    accept = cpu_boundary_i & sel_found & ~cpu_imask_i;
    state_next.cpu_req = accept;
    if (accept)
    begin
      state_next.vec = sel_vec;
      state_next.vec_addr = {10'h000, sel_vec, 1'b0};
    end

    // Block events
    evt_set[`EIP_EVT_EDGE] = (|edge_hit) | (|wake_hit);
    evt_set[`EIP_EVT_ACCEPT] = accept;
    evt_set[`EIP_EVT_HELD] = cpu_boundary_i & sel_found & cpu_imask_i;

    // Register reads, data one cycle later
    state_next.rdata = 8'h00;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `EIP_OFF_EDGE_POLARITY_SELECT:
          state_next.rdata = `EIP_EDGE_SEL_FIXED | {3'b000, state_reg.edge_sel};
        `EIP_OFF_SOURCE_ENABLE_FIRST:
          state_next.rdata = state_reg.enable_first;
        `EIP_OFF_SOURCE_ENABLE_SECOND:
          state_next.rdata = state_reg.enable_second;
        `EIP_OFF_PENDING_FLAGS_FIRST:
          state_next.rdata = state_reg.pending_first | `EIP_RST_PENDING_FLAGS_FIRST;
        `EIP_OFF_PENDING_FLAGS_SECOND:
          state_next.rdata = state_reg.pending_second;
        `EIP_OFF_WAKEUP_PENDING_FLAGS:
          state_next.rdata = state_reg.wake_pending;
        `EIP_OFF_EVENT_STATUS:
        begin
          state_next.rdata = {5'h00, state_reg.evt_status};
          status_rd = 1'b1;
        end
        `EIP_OFF_EVENT_MASK:
          state_next.rdata = {5'h00, state_reg.evt_mask};
        default:
          state_next.rdata = 8'h00;
      endcase
    end

    // Read clears status; a new event in that cycle survives
    state_next.evt_status = (status_rd ? 3'h0 : state_reg.evt_status) | evt_set;
    state_next.irq = |(state_next.evt_status & state_next.evt_mask);

    // Unimplemented edge-select bit of the reduced variant stays stored as written
    state_next.edge_sel = state_next.edge_sel & `EIP_EDGE_SEL_MASK;
    if (EDGE_MASK != `EIP_EDGE_SEL_MASK)
    begin
      // software keeps pin 2 select low; only its flag is masked off above, its edges still set the edge event
      state_next.edge_sel = state_next.edge_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg.edge_sel <= 5'h00;
      state_reg.enable_first <= `EIP_RST_SOURCE_ENABLE;
      state_reg.enable_second <= `EIP_RST_SOURCE_ENABLE;
      state_reg.pending_first <= 8'h00;
      state_reg.pending_second <= `EIP_RST_PENDING_FLAGS_SECOND;
      state_reg.wake_pending <= `EIP_RST_WAKEUP_PENDING_FLAGS;
      state_reg.edge_prev <= 5'h1f;
      state_reg.wake_prev <= 8'hff;
      state_reg.armed <= 1'b0;
      state_reg.evt_status <= `EIP_RST_EVENT;
      state_reg.evt_mask <= `EIP_RST_EVENT;
      state_reg.rdata <= 8'h00;
      state_reg.cpu_req <= 1'b0;
      state_reg.vec <= 5'h00;
      state_reg.vec_addr <= 16'h0000;
      state_reg.irq <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_o = state_reg.rdata;
  assign cpu_req_o = state_reg.cpu_req;
  assign cpu_vector_o = state_reg.vec;
  assign cpu_vec_addr_o = state_reg.vec_addr;
  assign irq_o = state_reg.irq;

endmodule

/* dv/eip_cpu_model.sv */
// Stand-in for the CPU core: instruction boundaries and the global mask
module eip_cpu_model (
  input wire logic clk_sys_i,
  input wire logic cpu_req_i,
  input wire eip_pkg::eip_vec_t cpu_vector_i,
  input wire eip_pkg::eip_addr_t cpu_vec_addr_i,
  output logic cpu_boundary_o,
  output logic cpu_imask_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import eip_pkg::*;
  initial
  begin
    cpu_boundary_o = 1'b0;
    cpu_imask_o = 1'b1;
  end
  // One instruction end after gap idle cycles, then what was taken
  task automatic step(input logic mask, input int gap, output logic got, output eip_vec_t vec, output eip_addr_t addr);
    repeat (gap) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    cpu_boundary_o <= 1'b1;
    cpu_imask_o <= mask;
    @(posedge clk_sys_i);
    cpu_boundary_o <= 1'b0;
    #1;
    got = cpu_req_i;
    vec = cpu_vector_i;
    addr = cpu_vec_addr_i;
  endtask
endmodule

/* dv/eip_monitor.sv */
// Port-level assertions for the interrupt prioritizer
module eip_monitor #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire eip_pkg::eip_addr_t reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire eip_pkg::eip_byte_t reg_rdata_o,
  input wire logic serial_three_req_i,
  input wire logic cpu_imask_i,
  input wire logic cpu_boundary_i,
  input wire logic cpu_req_o,
  input wire eip_pkg::eip_vec_t cpu_vector_o,
  input wire eip_pkg::eip_addr_t cpu_vec_addr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import eip_pkg::*;
  default clocking mon_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_take;
    cpu_boundary_i && !cpu_imask_i;
  endsequence
  // Flag-only acceptance, no write in it or the next cycle, then a boundary two cycles later
  sequence s_repeat;
    (s_take ##0 (!reg_wr_i && !serial_three_req_i)) ##1 (cpu_req_o && !reg_wr_i) ##1 s_take;
  endsequence
  ////////////////////
  addr_twice_a: assert property (cpu_req_o |-> cpu_vec_addr_o == {10'h000, cpu_vector_o, 1'b0})
    else $error("vector address not twice the vector");
  mask_blocks_a: assert property (cpu_imask_i |=> !cpu_req_o)
    else $error("request accepted while masked");
  at_boundary_a: assert property (cpu_req_o |-> $past(cpu_boundary_i) && !$past(cpu_imask_i))
    else $error("request without a boundary");
  vec_legal_a: assert property (cpu_req_o |-> cpu_vector_o inside {[5'h04:5'h0f], [5'h12:5'h14]})
    else $error("reserved vector selected");
  reduced_gap_a: assert property (cpu_req_o && !FULL_VARIANT |-> !(cpu_vector_o inside {5'h06, 5'h0a, 5'h0d}))
    else $error("absent source selected");
  vec_hold_a: assert property (!cpu_req_o |-> $stable(cpu_vector_o))
    else $error("vector changed without acceptance");
  sel_fixed_a: assert property (reg_rd_i && reg_addr_i == 16'hfff2 |=> reg_rdata_o[7:5] == 3'b111)
    else $error("edge select upper bits not ones");
  rank_first_a: assert property (s_take ##0 serial_three_req_i |=> cpu_req_o && cpu_vector_o <= 5'h12)
    else $error("lower priority vector chosen");
  flag_sticky_a: assert property (s_repeat |=> cpu_req_o)
    else $error("flag lost after acceptance");
endmodule

/* dv/eip_top_test.sv */
// Self-checking bench for the interrupt prioritizer
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module eip_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import eip_pkg::*;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  eip_addr_t reg_addr_i = '0;
  eip_byte_t reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  // Edge pins idle high, as the synchroniser and history reset to ones
  logic [4:0] edge_pin_i = 5'h1f;
  logic [7:0] wakeup_pin_n_i = 8'hff;
  logic [7:0] evt = '0;
  logic s3 = 1'b0;
  logic pol;
  int j;
  int n_mismatch = 0;
  int cmp_count = 0;
  eip_byte_t reg_rdata_o;
  eip_byte_t red_rdata_o;
  eip_byte_t red_wdata;
  eip_vec_t cpu_vector_o;
  eip_addr_t cpu_vec_addr_o;
  logic cpu_req_o, irq_o, cpu_imask_i, cpu_boundary_i;
  eip_addr_t rst_a[7] = '{16'hfff2, 16'hfff3, 16'hfff4, 16'hfff6, 16'hfff7, 16'hfff9, 16'hfff5};
  eip_byte_t rst_v[7] = '{8'he0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  // Peripheral sources in priority order: flag register, flag bit, vector
  eip_addr_t src_a[8] = '{16'hfff6, 16'hfff6, 16'hfff7, 16'hfff7, 16'hfff7, 16'hfff7, 16'hfff7, 16'hfff7};
  eip_byte_t src_b[8] = '{8'h40, 8'h80, 8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h80};
  eip_vec_t src_v[8] = '{5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h13, 5'h14};
  always #10 clk_sys_i = ~clk_sys_i;
  eip_top #(.FULL_VARIANT(1'b1)) eip_top_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .edge_pin_i(edge_pin_i), .wakeup_pin_n_i(wakeup_pin_n_i),
    .timer_a_evt_i(evt[1]), .serial_one_evt_i(evt[0]), .timer_b_evt_i(evt[2]), .timer_c_evt_i(evt[3]),
    .timer_fl_evt_i(evt[4]), .timer_fh_evt_i(evt[5]), .converter_evt_i(evt[6]),
    .direct_transfer_evt_i(evt[7]), .serial_three_req_i(s3), .cpu_imask_i(cpu_imask_i),
    .cpu_boundary_i(cpu_boundary_i), .cpu_req_o(cpu_req_o), .cpu_vector_o(cpu_vector_o),
    .cpu_vec_addr_o(cpu_vec_addr_o), .irq_o(irq_o));
  // Reduced variant beside the full one; its software never sets pin 2 select
  assign red_wdata = (reg_addr_i == 16'hfff2) ? (reg_wdata_i & 8'hfb) : reg_wdata_i;
  eip_top #(.FULL_VARIANT(1'b0)) eip_top_reduced_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(red_wdata), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(red_rdata_o), .edge_pin_i(edge_pin_i), .wakeup_pin_n_i(wakeup_pin_n_i),
    .timer_a_evt_i(evt[1]), .serial_one_evt_i(evt[0]), .timer_b_evt_i(evt[2]), .timer_c_evt_i(evt[3]),
    .timer_fl_evt_i(evt[4]), .timer_fh_evt_i(evt[5]), .converter_evt_i(evt[6]),
    .direct_transfer_evt_i(evt[7]), .serial_three_req_i(s3), .cpu_imask_i(cpu_imask_i),
    .cpu_boundary_i(cpu_boundary_i), .cpu_req_o(), .cpu_vector_o(), .cpu_vec_addr_o(), .irq_o());
  eip_cpu_model eip_cpu_model_i (.clk_sys_i(clk_sys_i), .cpu_req_i(cpu_req_o), .cpu_vector_i(cpu_vector_o),
    .cpu_vec_addr_i(cpu_vec_addr_o), .cpu_boundary_o(cpu_boundary_i), .cpu_imask_o(cpu_imask_i));
  ////////////////////
  function automatic eip_addr_t vaddr(input eip_vec_t v);
    return {10'h000, v, 1'b0};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input eip_addr_t a, input eip_byte_t d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input eip_addr_t a, input eip_byte_t e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("register", e, reg_rdata_o)
  endtask
  task automatic acc(input logic m, input int gap, input logic eg, input eip_vec_t ev);
    logic got;
    eip_vec_t v;
    eip_addr_t a;
    eip_cpu_model_i.step(m, gap, got, v, a);
    `CHK("accepted", eg, got)
    if (eg)
    begin
      `CHK("vector", ev, v)
      `CHK("vector address", vaddr(ev), a)
    end
  endtask
  task automatic fire(input logic [7:0] m);
    @(posedge clk_sys_i);
    evt <= m;
    @(posedge clk_sys_i);
    evt <= '0;
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////
  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'h4643));
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    foreach (rst_a[k]) rd_chk(rst_a[k], rst_v[k]);
    fire(8'hff);
    acc(1'b0, 1, 1'b0, 5'h00);
    wr(16'hfff3, 8'hff);
    wr(16'hfff4, 8'hff);
    acc(1'b1, 0, 1'b0, 5'h00);
    rd_chk(16'hfff6, 8'he0);
    `CHK("reduced first flags", 8'ha0, red_rdata_o)
    rd_chk(16'hfff7, 8'hcf);
    `CHK("reduced second flags", 8'hcd, red_rdata_o)
    for (int k = 0; k < 8; k++)
    begin
      if (k == 6)
      begin
        s3 <= 1'b1;
        acc(1'b0, $urandom_range(0, 2), 1'b1, 5'h12);
        s3 <= 1'b0;
      end
      acc(1'b0, $urandom_range(0, 2), 1'b1, src_v[k]);
      if (k == 0)
        acc(1'b0, 0, 1'b1, src_v[k]);
      wr(src_a[k], ~src_b[k]);
    end
    rd_chk(16'hfff6, 8'h20);
    rd_chk(16'hfff7, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      pol = 1'($urandom);
      wr(16'hfff2, 8'(pol) << i);
      rd_chk(16'hfff2, 8'he0 | (8'(pol) << i));
      @(posedge clk_sys_i) edge_pin_i[i] <= pol;
      idle(5);
      wr(16'hfff6, 8'h00);
      @(posedge clk_sys_i) edge_pin_i[i] <= !pol;
      idle(5);
      rd_chk(16'hfff6, 8'h20);
      @(posedge clk_sys_i) edge_pin_i[i] <= pol;
      idle(5);
      rd_chk(16'hfff6, 8'h20 | (8'h01 << i));
      acc(1'b0, $urandom_range(0, 2), 1'b1, 5'(4 + i));
      @(posedge clk_sys_i) edge_pin_i[i] <= 1'b1;
      idle(5);
      wr(16'hfff6, 8'h00);
    end
    j = $urandom_range(0, 7);
    @(posedge clk_sys_i) wakeup_pin_n_i[j] <= 1'b0;
    idle(5);
    rd_chk(16'hfff9, 8'h01 << j);
    acc(1'b0, 1, 1'b1, 5'h09);
    wr(16'hfff9, 8'h00);
    rd_chk(16'hfff9, 8'h00);
    `CHK("irq masked", 1'b0, irq_o)
    wr(16'hfffb, 8'h02);
    idle(3);
    `CHK("irq raised", 1'b1, irq_o)
    rd_chk(16'hfffa, 8'h07);
    idle(3);
    `CHK("irq cleared", 1'b0, irq_o)
    end_sim();
  end
endmodule
bind eip_top eip_monitor #(.FULL_VARIANT(FULL_VARIANT)) eip_monitor_i (.clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
  .reg_rdata_o(reg_rdata_o), .serial_three_req_i(serial_three_req_i), .cpu_imask_i(cpu_imask_i),
  .cpu_boundary_i(cpu_boundary_i), .cpu_req_o(cpu_req_o), .cpu_vector_o(cpu_vector_o),
  .cpu_vec_addr_o(cpu_vec_addr_o));
